//--- design/tai_defs.svh
// Constants for the temperature alarm and interrupt block
`ifndef TAI_DEFS_SVH
`define TAI_DEFS_SVH
`define TAI_ADDR_MAIN 7'h4C
`define TAI_ADDR_ALT 7'h4D
`define TAI_ARA_ADDR 7'h0C
`define TAI_REG_RD_LOC_TEMP 8'h00
`define TAI_REG_RD_EXT_TEMP 8'h01
`define TAI_REG_RD_STATUS 8'h02
`define TAI_REG_RD_CONFIG 8'h03
`define TAI_REG_WR_CONFIG 8'h09
`define TAI_REG_RD_LOC_HIGH 8'h05
`define TAI_REG_WR_LOC_HIGH 8'h0B
`define TAI_REG_RD_LOC_LOW 8'h06
`define TAI_REG_WR_LOC_LOW 8'h0C
`define TAI_REG_RD_EXT_HIGH 8'h07
`define TAI_REG_WR_EXT_HIGH 8'h0D
`define TAI_REG_RD_EXT_LOW 8'h08
`define TAI_REG_WR_EXT_LOW 8'h0E
`define TAI_REG_ONE_SHOT 8'h0F
`define TAI_REG_EXT_SHUT 8'h19
`define TAI_REG_LOC_SHUT 8'h20
`define TAI_REG_HYST 8'h21
`define TAI_RST_CONFIG 8'h00
`define TAI_RST_HIGH 8'h55
`define TAI_RST_LOW 8'h00
`define TAI_RST_EXT_SHUT 8'h6C
`define TAI_RST_LOC_SHUT 8'h55
`define TAI_RST_HYST 8'h0A
`define TAI_CFG_MASK_BIT 7
`define TAI_CFG_STANDBY_BIT 6
`define TAI_CFG_PIN_MODE_BIT 5
`define TAI_ST_BUSY_BIT 7
`define TAI_ST_LOC_HIGH_BIT 6
`define TAI_ST_LOC_LOW_BIT 5
`define TAI_ST_EXT_HIGH_BIT 4
`define TAI_ST_EXT_LOW_BIT 3
`define TAI_ST_OPEN_BIT 2
`define TAI_ST_EXT_SHUT_BIT 1
`define TAI_ST_LOC_SHUT_BIT 0
`define TAI_CONV_TIME_US 16
`define TAI_CONV_CYCLES (`TAI_CONV_TIME_US * 1000 / 10)
`endif

//--- design/tai_pkg.sv
// Types shared by the temperature alarm and interrupt block
package tai_pkg;
  typedef enum logic [1:0] {TAI_CONV_IDLE, TAI_CONV_RUN, TAI_CONV_DONE}
    tai_conv_t;
  typedef enum logic [2:0] {TAI_BUS_IDLE, TAI_BUS_ADDR, TAI_BUS_AACK,
    TAI_BUS_WBYTE, TAI_BUS_WACK, TAI_BUS_RBYTE, TAI_BUS_RACK}
    tai_bus_t;
endpackage : tai_pkg

//--- design/tai_sync.sv
// Two-flop synchroniser for an input from another clock domain
`timescale 1ns/10ps
`default_nettype none
module tai_sync
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_async,
  output logic o_sync
);
  logic meta_q;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      meta_q <= 1'b1;
      o_sync <= 1'b1;
    end
    else
    begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule : tai_sync
`default_nettype wire

//--- design/tai_shut_chan.sv
// One channel of shutdown comparison with hysteresis release
`timescale 1ns/10ps
`default_nettype none
module tai_shut_chan
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_temp,
  input wire logic [7:0] i_limit,
  input wire logic [7:0] i_hyst,
  output logic o_active
);
  logic signed [9:0] temp_s;
  logic signed [9:0] release_s;
  logic trip;
  logic clear;
  assign temp_s = {{2{i_temp[7]}}, i_temp};
  assign release_s = $signed({{2{i_limit[7]}}, i_limit})
    - $signed({2'b00, i_hyst});
  assign trip = $signed(i_temp) > $signed(i_limit);
  assign clear = temp_s <= release_s;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_active <= 1'b0;
    else if (trip)
      o_active <= 1'b1;
    else if (clear)
      o_active <= 1'b0;
  end
endmodule : tai_shut_chan
`default_nettype wire

//--- design/tai_alarm_top.sv
// Alarm, shutdown and serial slave logic of a two-channel temp monitor
`timescale 1ns/10ps
`default_nettype none
`include "tai_defs.svh"
module tai_alarm_top
  import tai_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = `TAI_ADDR_MAIN,
  parameter int CONV_CYCLES = `TAI_CONV_CYCLES
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_oe,
  input wire logic [7:0] i_loc_meas,
  input wire logic [7:0] i_ext_meas,
  input wire logic i_diode_open,
  input wire logic i_conv_tick,
  output logic o_alert_oe,
  output logic o_overtemp_shutdown_oe
);
  logic scl_s, sda_s, scl_p_q, sda_p_q;
  logic scl_rise, scl_fall, start_c, stop_c;
  tai_sync u_sync_scl (.i_clk(i_clk), .i_rst(i_rst), .i_async(i_scl),
    .o_sync(scl_s));
  tai_sync u_sync_sda (.i_clk(i_clk), .i_rst(i_rst), .i_async(i_sda),
    .o_sync(sda_s));
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // Register file
  logic [7:0] cfg_q, loc_hi_q, loc_lo_q, ext_hi_q, ext_lo_q;
  logic [7:0] ext_sh_q, loc_sh_q, hyst_q, loc_t_q, ext_t_q;
  logic open_q, st_lh_q, st_ll_q, st_eh_q, st_el_q;
  logic standby;
  assign standby = cfg_q[`TAI_CFG_STANDBY_BIT];

  // Limit comparisons on stored values, so they track new limits too
  logic lh_c, ll_c, eh_c, el_c, viol_c;
  assign lh_c = $signed(loc_t_q) > $signed(loc_hi_q);
  assign ll_c = $signed(loc_t_q) <= $signed(loc_lo_q);
  assign eh_c = $signed(ext_t_q) > $signed(ext_hi_q);
  assign el_c = $signed(ext_t_q) <= $signed(ext_lo_q);
  assign viol_c = lh_c | ll_c | eh_c | el_c;

  // Shutdown channels, and high-limit channels for the alert pin mode
  logic sh_loc, sh_ext, s2_loc, s2_ext;
  tai_shut_chan u_sh_loc (.i_clk(i_clk), .i_rst(i_rst), .i_temp(loc_t_q),
    .i_limit(loc_sh_q), .i_hyst(hyst_q), .o_active(sh_loc));
  tai_shut_chan u_sh_ext (.i_clk(i_clk), .i_rst(i_rst), .i_temp(ext_t_q),
    .i_limit(ext_sh_q), .i_hyst(hyst_q), .o_active(sh_ext));
  tai_shut_chan u_s2_loc (.i_clk(i_clk), .i_rst(i_rst), .i_temp(loc_t_q),
    .i_limit(loc_hi_q), .i_hyst(hyst_q), .o_active(s2_loc));
  tai_shut_chan u_s2_ext (.i_clk(i_clk), .i_rst(i_rst), .i_temp(ext_t_q),
    .i_limit(ext_hi_q), .i_hyst(hyst_q), .o_active(s2_ext));

  // Conversion sequencer
  tai_conv_t conv_q;
  logic [31:0] conv_cnt_q;
  logic one_shot_q, oneshot_req;
  logic conv_start, conv_end;
  assign conv_start = (conv_q == TAI_CONV_IDLE)
    & ((~standby & i_conv_tick) | one_shot_q);
  // An abort in the last cycle must not load the result
  assign conv_end = (conv_q == TAI_CONV_RUN) & ~(standby & ~one_shot_q)
    & (conv_cnt_q == 32'(CONV_CYCLES - 1));
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      conv_q <= TAI_CONV_IDLE;
      conv_cnt_q <= 32'h0;
    end
    else
    begin
      unique case (conv_q)
        TAI_CONV_IDLE:
          if (conv_start)
          begin
            conv_q <= TAI_CONV_RUN;
            conv_cnt_q <= 32'h0;
          end
        TAI_CONV_RUN:
          // Standby aborts unless it is the requested single shot
          if (standby & ~one_shot_q)
            conv_q <= TAI_CONV_IDLE;
          else if (conv_end)
            conv_q <= TAI_CONV_DONE;
          else
            conv_cnt_q <= conv_cnt_q + 32'h1;
        TAI_CONV_DONE:
          conv_q <= TAI_CONV_IDLE;
      endcase
    end
  end
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      one_shot_q <= 1'b0;
    else if (oneshot_req & standby)
      one_shot_q <= 1'b1;
    else if (conv_q == TAI_CONV_DONE)
      one_shot_q <= 1'b0;
  end
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      loc_t_q <= 8'h00;
      ext_t_q <= 8'h00;
    end
    else if (conv_end)
    begin
      loc_t_q <= i_loc_meas;
      ext_t_q <= i_ext_meas;
    end
  end

  // Serial slave
  tai_bus_t bus_q;
  logic [7:0] sh_q, ptr_q, tx_q;
  logic [3:0] bit_q;
  logic rd_q, ara_q, first_q, sda_oe_q, lost_q;
  logic [7:0] rd_data, status_c;
  logic addr_hit, ara_hit, wr_data_c, status_read;
  logic alarm_q, answered_q;
  assign status_c = {conv_q != TAI_CONV_IDLE, st_lh_q, st_ll_q, st_eh_q,
    st_el_q, open_q, sh_ext, sh_loc};
  always_comb
  begin
    unique case (ptr_q)
      `TAI_REG_RD_LOC_TEMP: rd_data = loc_t_q;
      `TAI_REG_RD_EXT_TEMP: rd_data = ext_t_q;
      `TAI_REG_RD_STATUS: rd_data = status_c;
      `TAI_REG_RD_CONFIG: rd_data = cfg_q;
      `TAI_REG_RD_LOC_HIGH: rd_data = loc_hi_q;
      `TAI_REG_RD_LOC_LOW: rd_data = loc_lo_q;
      `TAI_REG_RD_EXT_HIGH: rd_data = ext_hi_q;
      `TAI_REG_RD_EXT_LOW: rd_data = ext_lo_q;
      `TAI_REG_EXT_SHUT: rd_data = ext_sh_q;
      `TAI_REG_LOC_SHUT: rd_data = loc_sh_q;
      `TAI_REG_HYST: rd_data = hyst_q;
      default: rd_data = 8'h00;
    endcase
  end
  assign addr_hit = (sh_q[7:1] == SLAVE_ADDR);
  // Only an alarmed device takes the alert response address
  assign ara_hit = (sh_q[7:1] == `TAI_ARA_ADDR) & sh_q[0] & alarm_q;
  assign wr_data_c = (bus_q == TAI_BUS_WACK) & scl_fall & ~first_q;
  assign oneshot_req = wr_data_c & (ptr_q == `TAI_REG_ONE_SHOT);
  assign status_read = (bus_q == TAI_BUS_RACK) & scl_rise & ~ara_q
    & (ptr_q == `TAI_REG_RD_STATUS);

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst | stop_c)
    begin
      bus_q <= TAI_BUS_IDLE;
      sda_oe_q <= 1'b0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      rd_q <= 1'b0;
      ara_q <= 1'b0;
      first_q <= 1'b0;
      lost_q <= 1'b0;
    end
    else if (start_c)
    begin
      bus_q <= TAI_BUS_ADDR;
      sda_oe_q <= 1'b0;
      bit_q <= 4'h0;
      lost_q <= 1'b0;
    end
    else
    begin
      unique case (bus_q)
        TAI_BUS_IDLE: ;
        TAI_BUS_ADDR, TAI_BUS_WBYTE:
          if (scl_rise)
          begin
            sh_q <= {sh_q[6:0], sda_s};
            bit_q <= bit_q + 4'h1;
          end
          else if (scl_fall & (bit_q == 4'h8))
          begin
            bit_q <= 4'h0;
            if (bus_q == TAI_BUS_WBYTE)
            begin
              bus_q <= TAI_BUS_WACK;
              sda_oe_q <= 1'b1;
            end
            else if (addr_hit | ara_hit)
            begin
              bus_q <= TAI_BUS_AACK;
              sda_oe_q <= 1'b1;
              rd_q <= sh_q[0];
              ara_q <= ara_hit;
              first_q <= 1'b1;
              tx_q <= ara_hit ? {SLAVE_ADDR, 1'b1} : rd_data;
            end
            else
              bus_q <= TAI_BUS_IDLE;
          end
        TAI_BUS_AACK, TAI_BUS_WACK:
          if (scl_fall)
          begin
            if (bus_q == TAI_BUS_WACK)
              first_q <= 1'b0;
            if (rd_q)
            begin
              bus_q <= TAI_BUS_RBYTE;
              sda_oe_q <= ~tx_q[7];
              tx_q <= {tx_q[6:0], 1'b0};
              bit_q <= 4'h1;
            end
            else
            begin
              bus_q <= TAI_BUS_WBYTE;
              sda_oe_q <= 1'b0;
            end
          end
        TAI_BUS_RBYTE:
          if (scl_rise & ~sda_oe_q & ~sda_s & ~lost_q)
            lost_q <= 1'b1;
          else if (scl_fall)
          begin
            if (bit_q == 4'h8)
            begin
              bus_q <= TAI_BUS_RACK;
              sda_oe_q <= 1'b0;
            end
            else
            begin
              // A lost arbitration keeps the line released
              sda_oe_q <= ~tx_q[7] & ~lost_q;
              tx_q <= {tx_q[6:0], 1'b0};
              bit_q <= bit_q + 4'h1;
            end
          end
        TAI_BUS_RACK:
          if (scl_rise)
          begin
            if (sda_s | lost_q | ara_q)
              bus_q <= TAI_BUS_IDLE;
            else
            begin
              bus_q <= TAI_BUS_AACK;
              tx_q <= rd_data;
            end
          end
      endcase
    end
  end

  // Pointer and register writes
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ptr_q <= 8'h00;
      cfg_q <= `TAI_RST_CONFIG;
      loc_hi_q <= `TAI_RST_HIGH;
      loc_lo_q <= `TAI_RST_LOW;
      ext_hi_q <= `TAI_RST_HIGH;
      ext_lo_q <= `TAI_RST_LOW;
      ext_sh_q <= `TAI_RST_EXT_SHUT;
      loc_sh_q <= `TAI_RST_LOC_SHUT;
      hyst_q <= `TAI_RST_HYST;
    end
    else if (wr_data_c)
    begin
      unique case (ptr_q)
        `TAI_REG_WR_CONFIG: cfg_q <= sh_q;
        `TAI_REG_WR_LOC_HIGH: loc_hi_q <= sh_q;
        `TAI_REG_WR_LOC_LOW: loc_lo_q <= sh_q;
        `TAI_REG_WR_EXT_HIGH: ext_hi_q <= sh_q;
        `TAI_REG_WR_EXT_LOW: ext_lo_q <= sh_q;
        `TAI_REG_EXT_SHUT: ext_sh_q <= sh_q;
        `TAI_REG_LOC_SHUT: loc_sh_q <= sh_q;
        `TAI_REG_HYST: hyst_q <= sh_q;
        default: ;
      endcase
    end
    else if ((bus_q == TAI_BUS_WACK) & scl_fall & first_q)
      ptr_q <= sh_q;
  end

  // Sticky status: a new event wins over the read clear
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      open_q <= 1'b0;
      st_lh_q <= 1'b0;
      st_ll_q <= 1'b0;
      st_eh_q <= 1'b0;
      st_el_q <= 1'b0;
    end
    else
    begin
      if (conv_start)
        open_q <= i_diode_open | (open_q & ~status_read);
      else if (status_read)
        open_q <= 1'b0;
      st_lh_q <= lh_c | (st_lh_q & ~status_read);
      st_ll_q <= ll_c | (st_ll_q & ~status_read);
      st_eh_q <= eh_c | (st_eh_q & ~status_read);
      st_el_q <= el_c | (st_el_q & ~status_read);
    end
  end

  // Alarm latch: set by cause, released only after answer and clean
  logic cause_c, stat_clean, ara_done;
  assign cause_c = viol_c | open_q;
  assign stat_clean = ~(st_lh_q | st_ll_q | st_eh_q | st_el_q | open_q);
  assign ara_done = (bus_q == TAI_BUS_RACK) & scl_rise & ara_q & ~lost_q;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      alarm_q <= 1'b0;
      answered_q <= 1'b0;
    end
    else if (cause_c)
    begin
      alarm_q <= 1'b1;
      answered_q <= answered_q | ara_done;
    end
    else if (ara_done | answered_q)
    begin
      answered_q <= 1'b1;
      if (stat_clean)
      begin
        alarm_q <= 1'b0;
        answered_q <= 1'b0;
      end
    end
  end

  // Open-drain pins: only the enable ever toggles
  logic pin_mode_s2, alert_pin_c;
  assign pin_mode_s2 = cfg_q[`TAI_CFG_PIN_MODE_BIT];
  assign alert_pin_c = pin_mode_s2 ? (s2_loc | s2_ext)
    : (alarm_q & ~cfg_q[`TAI_CFG_MASK_BIT]);
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_alert_oe <= 1'b0;
      o_overtemp_shutdown_oe <= 1'b0;
      o_sda_oe <= 1'b0;
    end
    else
    begin
      o_alert_oe <= alert_pin_c;
      o_overtemp_shutdown_oe <= sh_loc | sh_ext;
      o_sda_oe <= sda_oe_q;
    end
  end
endmodule : tai_alarm_top
`default_nettype wire

//--- tb/tai_alarm_monitor.sv
// Assertion checker for the alarm, shutdown and serial data pins
`timescale 1ns/10ps
`default_nettype none
module tai_alarm_monitor
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_oe,
  input wire logic [7:0] i_loc_meas,
  input wire logic [7:0] i_ext_meas,
  input wire logic i_diode_open,
  input wire logic i_conv_tick,
  input wire logic o_alert_oe,
  input wire logic o_overtemp_shutdown_oe
);
  // Cycles since the device last pulled data low, saturating
  logic [11:0] idle_q;
  logic [7:0] hold_q;
  always_ff @(posedge i_clk)
  begin
    if (i_rst || o_sda_oe)
      idle_q <= 12'h000;
    else if (idle_q != 12'hFFF)
      idle_q <= idle_q + 12'h001;
  end
  always_ff @(posedge i_clk)
  begin
    if (i_rst || !o_sda_oe)
      hold_q <= 8'h00;
    else if (hold_q != 8'hFF)
      hold_q <= hold_q + 8'h01;
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  a_rst_quiet: assert property (disable iff (1'h0) i_rst |=>
    !o_alert_oe && !o_sda_oe && !o_overtemp_shutdown_oe)
    else $error("pins not released in reset");
  a_alarm_boot: assert property ($fell(i_rst) |-> ##[1:5] o_alert_oe)
    else $error("low limit alarm missing after reset");
  a_sda_low_phase: assert property ($changed(o_sda_oe) |->
    !i_scl && $past(i_scl, 3) == 1'h0)
    else $error("data changed outside clock low phase");
  a_sda_hold_max: assert property (hold_q < 8'hC8)
    else $error("data line held low too long");
  a_shut_cause: assert property ($rose(o_overtemp_shutdown_oe) |->
    $signed($past(i_loc_meas, 3)) > 8'sh55 ||
    $signed($past(i_ext_meas, 3)) > 8'sh6C)
    else $error("shutdown without a temperature above limit");
  a_shut_release: assert property ($fell(o_overtemp_shutdown_oe) |->
    $signed($past(i_loc_meas, 3)) <= 8'sh4B &&
    $signed($past(i_ext_meas, 3)) <= 8'sh62)
    else $error("shutdown released above limit minus hysteresis");
  a_open_alarm: assert property (i_conv_tick && i_diode_open |->
    ##[1:20] o_alert_oe)
    else $error("open diode did not raise alarm");
  a_alarm_release: assert property ($fell(o_alert_oe) |->
    idle_q < 12'hBB8)
    else $error("alarm released without bus service");
  c_shut: cover property ($rose(o_overtemp_shutdown_oe));
  c_release: cover property ($fell(o_alert_oe));
  c_ack: cover property (o_sda_oe ##1 !o_sda_oe);
endmodule : tai_alarm_monitor
bind tai_alarm_top tai_alarm_monitor mon_u (.i_clk(i_clk), .i_rst(i_rst),
  .i_scl(i_scl), .i_sda(i_sda), .o_sda_oe(o_sda_oe),
  .i_loc_meas(i_loc_meas), .i_ext_meas(i_ext_meas),
  .i_diode_open(i_diode_open), .i_conv_tick(i_conv_tick),
  .o_alert_oe(o_alert_oe), .o_overtemp_shutdown_oe(o_overtemp_shutdown_oe));
`default_nettype wire

//--- tb/tai_host_model.sv
// Serial bus host model, 160 ns bit clock, open-drain data
`timescale 1ns/10ps
`default_nettype none
module tai_host_model
(
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  // Clock idles high between frames, data released
  initial
  begin
    o_scl = 1'h1;
    o_sda_low = 1'h0;
  end
  task wt(input int n);
    repeat (n) @(negedge i_clk);
  endtask : wt
  task bitx(input logic b, output logic r);
    o_sda_low = !b;
    wt(4);
    o_scl = 1'h1;
    wt(4);
    r = i_sda;
    wt(4);
    o_scl = 1'h0;
    wt(4);
  endtask : bitx
  task start();
    wt(4);
    o_sda_low = 1'h1;
    wt(4);
    o_scl = 1'h0;
    wt(4);
  endtask : start
  task stop();
    o_sda_low = 1'h1;
    wt(4);
    o_scl = 1'h1;
    wt(4);
    o_sda_low = 1'h0;
    wt(16);
  endtask : stop
  // Sending all ones releases data, so a read is a write of 0xFF
  task xfer(input logic [7:0] w, input logic a, output logic [7:0] r,
    output logic k);
    logic n;
    for (int i = 7; i >= 0; i--)
      bitx(w[i], r[i]);
    bitx(a, n);
    k = !n;
  endtask : xfer
endmodule : tai_host_model
`default_nettype wire

//--- tb/tb_tai_alarm_top.sv
// Self-checking bench for the alarm and interrupt block
`timescale 1ns/10ps
`default_nettype none
`include "tai_defs.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; \
  $display("Error at %0t: got %h exp %h", $time, a, e); end end
module tb_tai_alarm_top
  import tai_pkg::*;
;
  logic i_clk = 1'h0;
  logic i_rst, scl, sda, sda_oe, host_low, diode, tick, alert, shut, k, j;
  logic [7:0] loc, ext, d;
  int err_total = 0;
  int n_tests = 0;
  always #5 i_clk = ~i_clk;
  // Wired data line with pull-up
  assign sda = !(host_low || sda_oe);
  tai_host_model host_u (.i_clk(i_clk), .i_sda(sda), .o_scl(scl),
    .o_sda_low(host_low));
  tai_alarm_top #(.CONV_CYCLES(8)) dut_u (.i_clk(i_clk), .i_rst(i_rst),
    .i_scl(scl), .i_sda(sda), .o_sda_oe(sda_oe), .i_loc_meas(loc),
    .i_ext_meas(ext), .i_diode_open(diode), .i_conv_tick(tick),
    .o_alert_oe(alert), .o_overtemp_shutdown_oe(shut));
  task wt(input int n);
    repeat (n) @(negedge i_clk);
  endtask : wt
  task end_of_test();
    $display("Checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  // Only the device's own address is used for ordinary access
  task reg_wr(input logic [7:0] p, input logic [7:0] v);
    host_u.start();
    host_u.xfer({`TAI_ADDR_MAIN, 1'h0}, 1'h1, d, k);
    `CHK(k, 1'h1)
    host_u.xfer(p, 1'h1, d, k);
    host_u.xfer(v, 1'h1, d, k);
    host_u.stop();
  endtask : reg_wr
  task reg_rd(input logic [7:0] p);
    host_u.start();
    host_u.xfer({`TAI_ADDR_MAIN, 1'h0}, 1'h1, d, k);
    host_u.xfer(p, 1'h1, d, k);
    host_u.stop();
    host_u.start();
    host_u.xfer({`TAI_ADDR_MAIN, 1'h1}, 1'h1, d, k);
    host_u.xfer(8'hFF, 1'h1, d, j);
    host_u.stop();
  endtask : reg_rd
  // Single device here, so one alert read per low line suffices
  task ara();
    host_u.start();
    host_u.xfer({`TAI_ARA_ADDR, 1'h1}, 1'h1, d, k);
    if (k)
      host_u.xfer(8'hFF, 1'h1, d, j);
    host_u.stop();
  endtask : ara
  task conv();
    tick = 1'h1;
    wt(1);
    tick = 1'h0;
    wt(30);
  endtask : conv
  initial
  begin
    #900us;
    err_total++;
    end_of_test();
  end
  initial
  begin
    i_rst = 1'h1;
    tick = 1'h0;
    diode = 1'h0;
    loc = 8'h00;
    ext = 8'h00;
    wt(3);
    i_rst = 1'h0;
    wt(10);
    `CHK(alert, 1'h1)
    reg_rd(`TAI_REG_HYST);
    `CHK(d, 8'h0A)
    reg_wr(`TAI_REG_WR_LOC_LOW, 8'h80);
    reg_wr(`TAI_REG_WR_EXT_LOW, 8'h80);
    `CHK(alert, 1'h1)
    reg_rd(`TAI_REG_RD_STATUS);
    `CHK(d, 8'h28)
    ara();
    `CHK(k, 1'h1)
    `CHK(d, 8'h99)
    `CHK(alert, 1'h0)
    ara();
    `CHK(k, 1'h0)
    diode = 1'h1;
    conv();
    diode = 1'h0;
    `CHK(alert, 1'h1)
    reg_rd(`TAI_REG_RD_STATUS);
    `CHK(d[2], 1'h1)
    conv();
    reg_rd(`TAI_REG_RD_STATUS);
    ara();
    `CHK(alert, 1'h0)
    loc = 8'h60;
    conv();
    `CHK(alert, 1'h1)
    `CHK(shut, 1'h1)
    loc = 8'h50;
    conv();
    `CHK(shut, 1'h1)
    loc = 8'h4B;
    conv();
    `CHK(shut, 1'h0)
    `CHK(alert, 1'h1)
    reg_wr(`TAI_REG_WR_CONFIG, 8'h40);
    loc = 8'h60;
    conv();
    `CHK(shut, 1'h0)
    reg_wr(`TAI_REG_ONE_SHOT, 8'h00);
    wt(30);
    `CHK(shut, 1'h1)
    loc = 8'h30;
    reg_wr(`TAI_REG_ONE_SHOT, 8'h00);
    wt(30);
    `CHK(shut, 1'h0)
    reg_rd(`TAI_REG_RD_STATUS);
    ara();
    `CHK(alert, 1'h0)
    reg_wr(`TAI_REG_WR_LOC_HIGH, 8'h20);
    `CHK(alert, 1'h1)
    reg_wr(`TAI_REG_WR_CONFIG, 8'hC0);
    `CHK(alert, 1'h0)
    reg_wr(`TAI_REG_WR_CONFIG, 8'h60);
    `CHK(alert, 1'h1)
    reg_wr(`TAI_REG_WR_LOC_HIGH, 8'h35);
    `CHK(alert, 1'h1)
    reg_wr(`TAI_REG_WR_LOC_HIGH, 8'h40);
    `CHK(alert, 1'h0)
    end_of_test();
  end
endmodule : tb_tai_alarm_top
`default_nettype wire
